/* logic/scd_top.v */
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "scd_defs.vh"
// Function
// - source: internal, clock in, star, strobe(acquire)
// - internal clock is reference divided by N
// - export only when source is not strobe
// - relative delay code, 10 ps steps, internal source only
// - export delay 1/256 period, fast only
// - rising, falling or delayed data position
// - generation delay 1/256 period, fast only
// - acquisition delay 1/256 period, fast only
// - export offset 0 or 2.5 ns, default 2.5
// - export invert independent of offset
// - per channel direction, data and function lines
// - per channel driver enable, off after reset
// - channel toggles at most half sample rate
// - strobe never reaches connector clock output
module scd_top #(
  parameter [22:0] N_MIN = 23'h00_0004
) (
  input wire hclk, // bus and reference clock
  input wire hresetn, // async reset, active low
  input wire hsel, // slave select
  input wire [31:0] haddr, // address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write when high
  input wire [2:0] hsize, // transfer size
  input wire [31:0] hwdata, // write data
  input wire hready, // bus ready
  output wire [31:0] hrdata, // read data
  output wire hreadyout, // slave ready
  output wire hresp, // always okay
  input wire clk_in_pin, // external clock input
  input wire star_pin, // backplane star line
  input wire strobe_pin, // external strobe
  input wire [31:0] data_in, // data channel inputs
  output wire [31:0] data_out, // data channel outputs
  output wire [31:0] data_oe, // data channel output enables
  input wire [3:0] programmable_function_line_in, // function line in
  output wire [3:0] programmable_function_line_out, // function line out
  output wire [3:0] programmable_function_line_oe, // function line oe
  output wire connector_clock_output, // exported clock, connector
  output wire coax_clock_output, // exported clock, coax
  output wire exp_offset_sel, // 1 selects 2.5 ns offset
  output wire [15:0] sclk_rel_delay, // relative delay code, 10 ps
  output wire [7:0] exp_delay, // export delay, 1/256 period
  output wire [7:0] gen_delay, // generation delay, 1/256 period
  output wire [7:0] acq_delay // acquisition delay, 1/256 period
);
  localparam SW = 3 + `SCD_NCH + `SCD_NPFI;
  localparam [22:0] FAST_N_MAX = `SCD_REF_MHZ / `SCD_FAST_MHZ;

  reg [`SCD_CTRL_W-1:0] ctrl_q;
  reg [22:0] div_q;
  reg [15:0] rel_q;
  reg [23:0] dly_q;
  reg [31:0] dir_q;
  reg [31:0] drv_q;
  reg [7:0] pfi_q;
  reg [31:0] gen_q;
  reg [31:0] acq_q;
  reg [1:0] act_src_q;
  reg sclk_q;
  reg exp_q;
  reg [31:0] dout_q;
  reg [31:0] doe_q;
  reg [7:0] xdly_q;
  reg [7:0] gdly_q;
  reg [7:0] adly_q;
  reg [15:0] rel_out_q;
  reg wr_q;
  reg rdp_q;
  reg rd_rdy_q;
  reg [7:0] addr_q;
  reg [31:0] hrdata_q;
  reg [31:0] rmux;
  reg [22:0] div_new;
  reg [`SCD_CTRL_W-1:0] ctrl_new;

  wire [SW-1:0] sync_out;
  wire int_lvl;
  wire clkin_s = sync_out[0];
  wire star_s = sync_out[1];
  wire strobe_s = sync_out[2];
  wire [31:0] din_s = sync_out[3 +: `SCD_NCH];
  wire [3:0] pfi_s = sync_out[3 + `SCD_NCH +: `SCD_NPFI];

  // every pin outside the bus passes two flops before any logic reads it
  scd_sync #(
    .W(SW)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({programmable_function_line_in, data_in, strobe_pin, star_pin,
      clk_in_pin}),
    .q(sync_out)
  );

  // hclk stands in for the reference; N counts its cycles
  scd_div #(
    .W(`SCD_DIV_W),
    .RST_N(N_MIN)
  ) u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .div_n(div_q),
    .lvl(int_lvl)
  );

  // source levels, indexed by source code
  wire [3:0] src_lvl = {strobe_s, star_s, clkin_s, int_lvl};
  wire [1:0] req_src = ctrl_q[`SCD_F_SRC];
  wire pending = (req_src != act_src_q);
  // change over only while old and new clock are both low
  wire do_switch = pending && !src_lvl[act_src_q] && !src_lvl[req_src];
  wire sel_lvl = src_lvl[act_src_q];
  wire sclk_rise = sel_lvl && !sclk_q;
  wire sclk_fall = !sel_lvl && sclk_q;
  wire strobe_act = (act_src_q == `SCD_SRC_STRB);
  wire exp_allow = ctrl_q[`SCD_B_EXP] && !strobe_act;
  // invert works on the level alone, so it is free of the offset choice
  wire exp_lvl = sel_lvl ^ ctrl_q[`SCD_B_INV];

  // delay lines are only calibrated for clocks of 25 MHz and up
  // an external clock cannot be timed here, so software vouches for it
  wire fast_ok = (act_src_q == `SCD_SRC_INT) ? (div_q <= FAST_N_MAX) :
    ctrl_q[`SCD_B_EXTF];
  wire [1:0] gpos = ctrl_q[`SCD_F_GPOS];
  wire [1:0] apos = ctrl_q[`SCD_F_APOS];
  // delayed mode takes the rising edge; the delay line adds the offset
  wire gen_edge = (gpos == `SCD_POS_FALL) ? sclk_fall : sclk_rise;
  // strobe clocks acquisition only, so generation holds still on it
  wire launch = gen_edge && !strobe_act;
  wire capture = (apos == `SCD_POS_FALL) ? sclk_fall : sclk_rise;

  wire ap = hsel && htrans[1] && hready;
  wire [7:0] ap_addr = {haddr[7:2], 2'b00};
  // status is read live; pending drops once both levels sit low
  wire [7:0] stat_bits = {pfi_s, fast_ok, pending, act_src_q};

  // divider writes are clamped into the legal range of N
  always @*
  begin
    div_new = hwdata[22:0];
    if (hwdata[31:23] != 9'h000 || hwdata[22:0] > `SCD_N_MAX)
      div_new = `SCD_N_MAX;
    else if (hwdata[22:0] < N_MIN)
      div_new = N_MIN;
  end

  // strobe may only be picked for acquisition
  always @*
  begin
    ctrl_new = hwdata[`SCD_CTRL_W-1:0];
    if (ctrl_new[`SCD_F_SRC] == `SCD_SRC_STRB && !ctrl_new[`SCD_B_ACQ])
    begin
      if (ctrl_q[`SCD_F_SRC] == `SCD_SRC_STRB)
        ctrl_new[`SCD_F_SRC] = `SCD_SRC_INT;
      else
        ctrl_new[`SCD_F_SRC] = ctrl_q[`SCD_F_SRC];
    end
  end

  always @*
  begin
    rmux = 32'h0000_0000;
    case (addr_q)
      `SCD_A_CTRL: rmux = {21'h00_0000, ctrl_q};
      `SCD_A_DIV: rmux = {9'h000, div_q};
      `SCD_A_REL: rmux = {16'h0000, rel_q};
      `SCD_A_DLY: rmux = {8'h00, dly_q};
      `SCD_A_DIR: rmux = dir_q;
      `SCD_A_DRV: rmux = drv_q;
      `SCD_A_PFI: rmux = {24'h00_0000, pfi_q};
      `SCD_A_GEN: rmux = gen_q;
      `SCD_A_ACQ: rmux = acq_q;
      `SCD_A_STAT: rmux = {24'h00_0000, stat_bits};
      default: rmux = 32'h0000_0000;
    endcase
  end

  // bus phases: writes take no wait, reads one wait state
  // the wait state lets read data come from a flop, not the mux
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      rdp_q <= 1'b0;
      rd_rdy_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      wr_q <= 1'b0;
      if (rd_rdy_q)
      begin
        rdp_q <= 1'b0;
        rd_rdy_q <= 1'b0;
      end
      else if (rdp_q)
      begin
        hrdata_q <= rmux;
        rd_rdy_q <= 1'b1;
      end
      if (ap)
      begin
        addr_q <= ap_addr;
        wr_q <= hwrite && (hsize == `SCD_HSIZE_WORD);
        rdp_q <= !hwrite;
      end
    end
  end

  // register file
  // the read-only words and holes in the map drop writes
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= `SCD_CTRL_RST;
      div_q <= N_MIN;
      rel_q <= 16'h0000;
      dly_q <= 24'h00_0000;
      dir_q <= 32'h0000_0000;
      drv_q <= 32'h0000_0000;
      pfi_q <= 8'h00;
      gen_q <= 32'h0000_0000;
    end
    else if (wr_q)
    begin
      case (addr_q)
        `SCD_A_CTRL: ctrl_q <= ctrl_new;
        `SCD_A_DIV: div_q <= div_new;
        `SCD_A_REL: rel_q <= hwdata[15:0];
        `SCD_A_DLY: dly_q <= hwdata[23:0];
        `SCD_A_DIR: dir_q <= hwdata;
        `SCD_A_DRV: drv_q <= hwdata;
        `SCD_A_PFI: pfi_q <= hwdata[7:0];
        `SCD_A_GEN: gen_q <= hwdata;
        default: gen_q <= gen_q;
      endcase
    end
  end

  // clock selection, export and data timing
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      act_src_q <= `SCD_SRC_INT;
      sclk_q <= 1'b0;
      exp_q <= 1'b0;
      dout_q <= 32'h0000_0000;
      doe_q <= 32'h0000_0000;
      acq_q <= 32'h0000_0000;
      xdly_q <= 8'h00;
      gdly_q <= 8'h00;
      adly_q <= 8'h00;
      rel_out_q <= 16'h0000;
    end
    else
    begin
      if (do_switch)
        act_src_q <= req_src;
      // the last level is kept to find edges of the selected clock
      sclk_q <= sel_lvl;
      // strobe never reaches either clock output
      exp_q <= exp_allow && exp_lvl;
      // a channel changes at most once per sample period
      if (launch)
        dout_q <= gen_q;
      if (capture)
        acq_q <= din_s;
      // a pin drives only with both direction and enable set
      doe_q <= dir_q & drv_q;
      rel_out_q <= (act_src_q == `SCD_SRC_INT) ? rel_q : 16'h0000;
      xdly_q <= fast_ok ? dly_q[`SCD_F_XDLY] : 8'h00;
      gdly_q <= (fast_ok && gpos == `SCD_POS_DLY) ?
        dly_q[`SCD_F_GDLY] : 8'h00;
      adly_q <= (fast_ok && apos == `SCD_POS_DLY) ?
        dly_q[`SCD_F_ADLY] : 8'h00;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = !(rdp_q && !rd_rdy_q);
  assign hresp = 1'b0;
  assign data_out = dout_q;
  assign data_oe = doe_q;
  assign programmable_function_line_out = pfi_q[`SCD_F_POUT];
  assign programmable_function_line_oe = pfi_q[`SCD_F_PDIR];
  // both clock pins share one flop, so they cannot skew
  assign connector_clock_output = exp_q;
  assign coax_clock_output = exp_q;
  assign exp_offset_sel = ctrl_q[`SCD_B_OFS];
  assign sclk_rel_delay = rel_out_q;
  assign exp_delay = xdly_q;
  assign gen_delay = gdly_q;
  assign acq_delay = adly_q;
endmodule
`default_nettype wire

/* inc/scd_defs.vh */
`ifndef SCD_DEFS_VH
`define SCD_DEFS_VH
// register byte offsets
`define SCD_A_CTRL 8'h00
`define SCD_A_DIV 8'h04
`define SCD_A_REL 8'h08
`define SCD_A_DLY 8'h0C
`define SCD_A_DIR 8'h10
`define SCD_A_DRV 8'h14
`define SCD_A_PFI 8'h18
`define SCD_A_GEN 8'h1C
`define SCD_A_ACQ 8'h20
`define SCD_A_STAT 8'h24
// control fields
`define SCD_CTRL_W 11
`define SCD_CTRL_RST 11'h020
`define SCD_F_SRC 1:0
`define SCD_B_ACQ 2
`define SCD_B_EXP 3
`define SCD_B_INV 4
`define SCD_B_OFS 5
`define SCD_F_GPOS 7:6
`define SCD_F_APOS 9:8
`define SCD_B_EXTF 10
// delay fields
`define SCD_F_XDLY 7:0
`define SCD_F_GDLY 15:8
`define SCD_F_ADLY 23:16
// pfi fields
`define SCD_F_PDIR 3:0
`define SCD_F_POUT 7:4
// sample clock sources
`define SCD_SRC_INT 2'h0
`define SCD_SRC_CLKIN 2'h1
`define SCD_SRC_STAR 2'h2
`define SCD_SRC_STRB 2'h3
// data position modes
`define SCD_POS_RISE 2'h0
`define SCD_POS_FALL 2'h1
`define SCD_POS_DLY 2'h2
// divider
`define SCD_DIV_W 23
`define SCD_N_MAX 23'h40_0000
`define SCD_REF_MHZ 23'h00_00c8
`define SCD_FAST_MHZ 23'h00_0019
// channel counts and word transfer size
`define SCD_NCH 32
`define SCD_NPFI 4
`define SCD_HSIZE_WORD 3'h2
`endif

/* logic/scd_sync.v */
`timescale 1ns/10ps
`default_nettype none
module scd_sync #(
  parameter W = 1
) (
  input wire hclk, // clock
  input wire hresetn, // async reset, active low
  input wire [W-1:0] d, // asynchronous inputs
  output wire [W-1:0] q // synchronised outputs
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule
`default_nettype wire

/* logic/scd_div.v */
`timescale 1ns/10ps
`default_nettype none
module scd_div #(
  parameter W = 23,
  parameter [W-1:0] RST_N = {{(W-3){1'b0}}, 3'h4}
) (
  input wire hclk, // reference clock
  input wire hresetn, // async reset, active low
  input wire [W-1:0] div_n, // requested divide ratio, at least 2
  output wire lvl // divided clock level
);
  reg [W-1:0] cnt_q;
  reg [W-1:0] n_q;
  reg lvl_q;
  wire [W-1:0] one = {{(W-1){1'b0}}, 1'b1};
  wire [W-1:0] last = n_q - one;
  wire [W-1:0] cnt_inc = cnt_q + one;
  wire [W-1:0] half = {1'b0, n_q[W-1:1]};

  // a new ratio is only taken at a period boundary, so no runt pulse
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_q <= {W{1'b0}};
      n_q <= RST_N;
      lvl_q <= 1'b1;
    end
    else if (cnt_q == last)
    begin
      cnt_q <= {W{1'b0}};
      n_q <= div_n;
      lvl_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_inc;
      lvl_q <= (cnt_inc < half);
    end
  end

  assign lvl = lvl_q;
endmodule
`default_nettype wire

/* sim/scd_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module scd_monitor (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, low
  input wire logic hsel, // in
  input wire logic [1:0] htrans, // in
  input wire logic hwrite, // in
  input wire logic hready, // in
  input wire logic hreadyout, // out
  input wire logic hresp, // out
  input wire logic [31:0] data_out, // out
  input wire logic [31:0] data_oe, // out
  input wire logic connector_clock_output, // out
  input wire logic coax_clock_output, // out
  input wire logic exp_offset_sel, // out
  input wire logic [7:0] exp_delay, // out
  input wire logic [7:0] gen_delay, // out
  input wire logic [7:0] acq_delay // out
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire req = hsel && htrans[1] && hready;
  a_write_nowait: assert property (req && hwrite |=> hreadyout)
    else $error("write waited");
  a_read_wait: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  a_idle_ready: assert property (hreadyout && !req |=> hreadyout)
    else $error("idle wait");
  a_resp_okay: assert property (!hresp)
    else $error("response not okay");
  a_coax_match: assert property (
    coax_clock_output == connector_clock_output)
    else $error("clock outputs differ");
  a_reset_state: assert property ($rose(hresetn) |->
    data_oe == 32'h0 && exp_offset_sel)
    else $error("reset state wrong");
  a_delay_reset: assert property ($rose(hresetn) |->
    {exp_delay, gen_delay, acq_delay} == 24'h0)
    else $error("delay not cleared");
  // one update per sample period keeps toggling at half rate at most
  a_data_rate: assert property ($changed(data_out) |=>
    $stable(data_out))
    else $error("data toggled too fast");
endmodule
bind scd_top scd_monitor mon_u (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .data_out, .data_oe, .connector_clock_output,
  .coax_clock_output, .exp_offset_sel, .exp_delay, .gen_delay, .acq_delay);
`default_nettype wire

/* sim/scd_far_end.sv */
`timescale 1ns/10ps
`default_nettype none
module scd_far_end (
  input wire logic [2:0] run, // toggling lines: strobe, star, clock in
  input wire logic slow, // long period when high
  input wire logic [31:0] word, // pattern sent to the device
  output logic clk_in_pin, // clock line
  output logic star_pin, // star line
  output logic strobe_pin, // strobe line
  output logic [31:0] data_in, // data lines
  output logic [3:0] fn_in // function lines
);
  logic ph = 1'b0;
  logic [2:0] en = 3'h0;
  // odd start keeps line edges away from the device clock edges
  initial
  begin
    #7;
    forever #(slow ? 300 : 100) ph = ~ph;
  end
  // lines start and stop only while low, so no runt pulse
  always @(negedge ph) en <= run;
  assign {strobe_pin, star_pin, clk_in_pin} = en & {3{ph}};
  assign data_in = word;
  assign fn_in = word[3:0];
endmodule
`default_nettype wire

/* sim/scd_top_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "scd_defs.vh"
module scd_top_bench;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, run = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, word = 32'h0, lf = 32'h39;
  logic [31:0] rd, g, f, c;
  wire hready, hresp, cko, cxo, ofs, ck, st, sb;
  wire [31:0] hrdata, dout, doe, din;
  wire [3:0] fin, fout, foe;
  wire [15:0] rel;
  wire [7:0] xd, gd, ad;
  int err_count = 0, n_checks = 0, cyc = 0, hi, per, n;
  scd_far_end far_u (.run(run), .slow(slow), .word(word), .clk_in_pin(ck),
    .star_pin(st), .strobe_pin(sb), .data_in(din), .fn_in(fin));
  scd_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .clk_in_pin(ck),
    .star_pin(st), .strobe_pin(sb), .data_in(din), .data_out(dout),
    .data_oe(doe), .programmable_function_line_in(fin),
    .programmable_function_line_out(fout),
    .programmable_function_line_oe(foe), .connector_clock_output(cko),
    .coax_clock_output(cxo), .exp_offset_sel(ofs), .sclk_rel_delay(rel),
    .exp_delay(xd), .gen_delay(gd), .acq_delay(ad));
  initial forever #20 hclk = ~hclk;
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] msk(input logic [7:0] a);
    case (a)
      8'h08: return 32'h0000_ffff;
      8'h0c: return 32'h00ff_ffff;
      8'h18: return 32'h0000_00ff;
      default: return 32'hffff_ffff;
    endcase
  endfunction
  // high time is the floor half, the longer part when inverted
  function automatic int hi_x(input int m, input logic inv);
    return inv ? m - m / 2 : m / 2;
  endfunction
  task automatic give_verdict;
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [2:0] sz);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hsize <= sz;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, `SCD_HSIZE_WORD);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, logic [31:0] e);
    xfer(1'b0, a, 32'h0, `SCD_HSIZE_WORD);
    chk(nm, e, rd);
  endtask
  task automatic meas(output int h, p);
    int t;
    for (t = 0; t < 400 && cko !== 1'b0; t++) @(posedge hclk);
    for (t = 0; t < 400 && cko !== 1'b1; t++) @(posedge hclk);
    for (h = 0; h < 400 && cko === 1'b1; h++) @(posedge hclk);
    for (p = h; p < 400 && cko !== 1'b1; p++) @(posedge hclk);
  endtask
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      err_count++;
      give_verdict;
    end
  end
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("ctrl", `SCD_A_CTRL, {21'h0, `SCD_CTRL_RST});
    rdc("div", `SCD_A_DIV, 32'h4);
    rdc("drive", `SCD_A_DRV, 32'h0);
    rdc("hole", 8'h28, 32'h0);
    chk("offset", 32'h1, {31'h0, ofs});
    for (int i = 0; i < 12; i++)
    begin
      lf = nx(lf);
      c = 32'h8 + 4 * (i % 6);
      if (i == 8) g = lf;
      if (i == 9) g &= lf;
      if (i == 10) f = lf;
      wr(c[7:0], lf);
      rdc("reg", c[7:0], lf & msk(c[7:0]));
    end
    // byte write must leave the enables alone
    xfer(1'b1, `SCD_A_DRV, 32'h0, 3'h0);
    repeat (2) @(posedge hclk);
    chk("oe", g, doe);
    chk("func", f & 32'hff, {fout, foe});
    wr(`SCD_A_REL, 32'h1234);
    wr(`SCD_A_DLY, 32'h003c_5aa5);
    for (int k = 0; k < 4; k++)
    begin
      n = (k == 3) ? 1 : 5 + k;
      lf = nx(lf);
      word <= lf;
      wr(`SCD_A_GEN, lf);
      wr(`SCD_A_DIV, n);
      wr(`SCD_A_CTRL, 32'h8 | k[0] << 4 | k[1] << 5 | (k % 3) * 32'h140);
      repeat (20) @(posedge hclk);
      meas(hi, per);
      n = (n < 4) ? 4 : n;
      chk("period", n, per);
      chk("high", hi_x(n, k[0]), hi);
      chk("offset", k[1], ofs);
      chk("gen", lf, dout);
      chk("gdly", k % 3 == 2 ? 32'h5a : 32'h0, gd);
      chk("adly", k % 3 == 2 ? 32'h3c : 32'h0, ad);
      chk("xdly", 32'ha5, xd);
      chk("rel", 32'h1234, rel);
      rdc("acq", `SCD_A_ACQ, lf);
    end
    wr(`SCD_A_CTRL, 32'h288);
    wr(`SCD_A_DIV, 32'h10);
    repeat (40) @(posedge hclk);
    chk("slow", 32'h0, xd | gd | ad);
    for (int s = 1; s < 3; s++)
    begin
      run <= s[2:0];
      slow <= s[1];
      wr(`SCD_A_CTRL, 32'h408 | s);
      repeat (60) @(posedge hclk);
      meas(hi, per);
      chk("ext", s[1] ? 15 : 5, per);
      xfer(1'b0, `SCD_A_STAT, 32'h0, `SCD_HSIZE_WORD);
      chk("src", s, rd[1:0]);
      chk("stat", {24'h0, word[3:0], 2'h2, s[1:0]}, rd);
      chk("rel ext", 32'h0, rel);
      chk("xdly", 32'ha5, xd);
    end
    wr(`SCD_A_CTRL, 32'hb);
    rdc("refuse", `SCD_A_CTRL, 32'ha);
    run <= 3'h4;
    lf = nx(lf);
    word <= lf;
    wr(`SCD_A_CTRL, 32'hf);
    repeat (60) @(posedge hclk);
    rdc("strobe acq", `SCD_A_ACQ, lf);
    g = 32'h0;
    repeat (50) @(posedge hclk) g |= {cko, cxo};
    chk("strobe out", 32'h0, g);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("oe reset", 32'h0, doe);
    give_verdict;
  end
endmodule
`default_nettype wire
